// ==== pkg/fbm_pkg.sv ====
/*
  Constants, types and register map of the flyback mode and limit mapper.
  Assumes a 25 MHz controller clock and feedback levels in millivolts.
*/
`default_nettype none
package fbm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int HALF_LINE_PRESET_NS = 9823000;
  localparam int HALF_LINE_PRESET_CYC = HALF_LINE_PRESET_NS / CLK_PERIOD_NS;
  localparam int LEB_TIME_NS = 480;
  localparam int LEB_CYC = (LEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_PERIOD_NS = 50000;
  localparam int BURST_PERIOD_CYC = BURST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_SHIFT = 6;
  localparam logic [15:0] BURST_SWITCH_PERIOD = 16'(BURST_PERIOD_CYC);
  localparam logic [4:0] LEB_COUNT = 5'(LEB_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Feedback levels, mV
  localparam logic [15:0] BURST_ENTRY_THRESHOLD = 16'h0320;
  localparam logic [15:0] ONTIME_CONTROL_THRESHOLD = 16'h04B0;
  localparam logic [15:0] MAX_FREQUENCY_THRESHOLD = 16'h07D0;
  localparam logic [15:0] CEILING_RAMP_START = 16'h04B0;
  localparam logic [15:0] CEILING_RAMP_FINAL = 16'h097C;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam int CFG_N = 18;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_TON_MIN = 5'h01;
  localparam logic [4:0] REG_TON_MAX_LOW = 5'h02;
  localparam logic [4:0] REG_FOLDBACK_GAIN = 5'h03;
  localparam logic [4:0] REG_VIN_LOW = 5'h04;
  localparam logic [4:0] REG_VIN_HIGH = 5'h05;
  localparam logic [4:0] REG_OCP_LOW = 5'h06;
  localparam logic [4:0] REG_OCP_HIGH = 5'h07;
  localparam logic [4:0] REG_PERIOD_MIN = 5'h08;
  localparam logic [4:0] REG_BURST_BLANK = 5'h09;
  localparam logic [4:0] REG_BURST_PULSES = 5'h0A;
  localparam logic [4:0] REG_BURST_ON = 5'h0B;
  localparam logic [4:0] REG_FB_FLOOR = 5'h0C;
  localparam logic [4:0] REG_FB_FULL = 5'h0D;
  localparam logic [4:0] REG_RAMP_INC = 5'h0E;
  localparam logic [4:0] REG_DEMAG_MIN = 5'h0F;
  localparam logic [4:0] REG_VOUT_OV = 5'h10;
  localparam logic [4:0] REG_BURST_REPEAT = 5'h11;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_TON_STAT = 5'h15;
  localparam logic [4:0] REG_PER_STAT = 5'h16;
  localparam int CTRL_IN_PROT_BIT = 0;

  // Reset values in index order
  localparam logic [15:0] CFG_RESET [0:CFG_N-1] = '{
    16'h0000, 16'h000A, 16'h0190, 16'h0100, 16'h0064, 16'h012C,
    16'h0320, 16'h0258, 16'h0064, 16'h2710, 16'h0002, 16'h0008,
    16'h0258, 16'h0960, 16'h0010, 16'h0032, 16'h0064, 16'h61A8};

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    DISCONTINUOUS_MODE = 2'b00,
    FIRST_VALLEY_MODE = 2'b01,
    BURST_MODE = 2'b10
  } fbm_mode_t;

  typedef struct packed {
    fbm_mode_t mode;
    logic [15:0] ton_min;
    logic [15:0] ton_max;
    logic [15:0] ton_cmd;
    logic [15:0] period;
    logic [15:0] pulses;
    logic [15:0] ocp;
  } fbm_limits_t;

endpackage : fbm_pkg
`default_nettype wire

// ==== logic/fbm_mapper.sv ====
/*
  Flyback mode and limit mapper: maps filtered feedback and estimated input
  onto operating mode, on-time limits, period, burst pulses and current limit.
  Assumes feedback filter, estimators and gate generator on the same clock;
  only the current-sense comparator comes from a pin.
*/
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Between burst and on-time threshold: period control
// - Above on-time threshold, long period: stay discontinuous
// - Enter first valley when period drops below
// - First valley regulates on-time only
// - Burst entry after blanked low feedback
// - Burst uses fixed period, configured repetition
// - Burst pulses from feedback at last pulse
// - Leave burst when feedback exceeds threshold
// - At floor: minimum burst on-time, pulses
// - Burst disables output, optionally input, protections
// - Sensing minimum on-time from demagnetization time
// - Minimum on-time is larger of two
// - Maximum on-time scales inversely with input
// - Brown-out foldback reduces maximum on-time
// - On-time limits recomputed each half-line
// - Minimum period falls with feedback, then holds
// - Current limit interpolated, clamped at ends
// - Full power: maximum on-time or current limit
// - Current limit ignored during leading-edge blanking
// - Current limit updated once per half-line
// - Feedback ceiling ramps on regulated entry
// - Map from ceiling while feedback exceeds it
// - Sample feedback 64 times per half-line
module fbm_mapper
  import fbm_pkg::*;
#(
  parameter int HALF_LINE_CYCLES = HALF_LINE_PRESET_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] feedback_level_filtered,
  input wire logic [15:0] vin_estimate,
  input wire logic [15:0] vin_peak,
  input wire logic [15:0] first_valley_period,
  input wire logic line_sync_valid,
  input wire logic [23:0] line_half_period,
  input wire logic regulated_entry,
  input wire logic cycle_start,
  input wire logic gate_on,
  input wire logic burst_last_pulse,
  input wire logic burst_sleep,
  input wire logic cs_over_pin,
  output fbm_limits_t limits,
  output logic [15:0] burst_repeat_period,
  output logic cs_limit_hit,
  output logic feedback_sample,
  output logic out_protect_enable,
  output logic in_protect_enable,
  output logic half_line_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Linear interpolation, clamped at both ends
  function automatic logic [15:0] interp(
    input logic [15:0] y0,
    input logic [15:0] y1,
    input logic [15:0] x,
    input logic [15:0] x0,
    input logic [15:0] x1
  );
    logic signed [33:0] dy;
    logic signed [33:0] r;
    dy = 34'(signed'({1'b0, y1})) - 34'(signed'({1'b0, y0}));
    if (x <= x0 || x1 <= x0) begin
      r = 34'(signed'({1'b0, y0}));
    end else if (x >= x1) begin
      r = 34'(signed'({1'b0, y1}));
    end else begin
      r = 34'(signed'({1'b0, y0}))
        + (dy * signed'(34'(x - x0))) / signed'(34'(x1 - x0));
    end
    return r[15:0];
  endfunction : interp

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] cfg [0:CFG_N-1];
  fbm_mode_t mode;
  fbm_mode_t next_mode;
  logic [15:0] ceiling;
  logic [15:0] fb_map;
  logic [15:0] fb_burst;
  logic [15:0] ton_min_hl;
  logic [15:0] ton_max_hl;
  logic [15:0] ocp_hl;
  logic [15:0] min_period;
  logic [15:0] low_cnt;
  logic [23:0] hl_cnt;
  logic [23:0] hl_len;
  logic [23:0] smp_cnt;
  logic smp_due;
  logic [4:0] leb_cnt;
  logic cs_meta;
  logic cs_s2;
  logic cs_s3;
  logic cs_level;
  logic [15:0] ton_sense;
  logic [15:0] ton_eff;
  logic [15:0] ton_max_calc;
  logic [15:0] ocp_calc;
  logic [15:0] burst_ton;
  logic [15:0] burst_pulses;
  logic [15:0] ton_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < CFG_N; i++) begin
        cfg[i] <= CFG_RESET[i];
      end
    end else if (reg_wr && reg_addr < 5'(CFG_N)) begin
      cfg[reg_addr] <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr < 5'(CFG_N)) begin
        reg_rdata <= {16'h0000, cfg[reg_addr]};
      end else if (reg_addr == REG_STATUS) begin
        reg_rdata <= {14'h0000, mode, ceiling};
      end else if (reg_addr == REG_TON_STAT) begin
        reg_rdata <= {limits.ton_max, limits.ton_min};
      end else if (reg_addr == REG_PER_STAT) begin
        reg_rdata <= {limits.ocp, limits.period};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-line tick and sample pacing
  always_comb begin
    if (line_sync_valid && mode != BURST_MODE && line_half_period != 24'h0) begin
      hl_len = line_half_period;
    end else begin
      hl_len = 24'(HALF_LINE_CYCLES);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hl_cnt <= 24'h00_0000;
      half_line_tick <= 1'b0;
    end else if (hl_cnt + 24'h00_0001 >= hl_len) begin
      hl_cnt <= 24'h00_0000;
      half_line_tick <= 1'b1;
    end else begin
      hl_cnt <= hl_cnt + 24'h00_0001;
      half_line_tick <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      smp_cnt <= 24'h00_0000;
    end else if (smp_cnt + 24'h00_0001 >= (hl_len >> SAMPLE_SHIFT)) begin
      smp_cnt <= 24'h00_0000;
    end else begin
      smp_cnt <= smp_cnt + 24'h00_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Leading-edge blanking, sense input and feedback sample strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      cs_meta <= 1'b0;
      cs_s2 <= 1'b0;
      cs_s3 <= 1'b0;
      cs_level <= 1'b0;
    end else begin
      cs_meta <= cs_over_pin;
      cs_s2 <= cs_meta;
      cs_s3 <= cs_s2;
      if (cs_s2 == cs_s3) begin
        cs_level <= cs_s3;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      leb_cnt <= 5'h00;
    end else if (cycle_start) begin
      leb_cnt <= LEB_COUNT;
    end else if (leb_cnt != 5'h00) begin
      leb_cnt <= leb_cnt - 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cs_limit_hit <= 1'b0;
    end else begin
      cs_limit_hit <= gate_on && !cycle_start && leb_cnt == 5'h00
        && cs_level;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      smp_due <= 1'b0;
      feedback_sample <= 1'b0;
    end else begin
      feedback_sample <= 1'b0;
      if (smp_due && leb_cnt == 5'h01 && !burst_sleep) begin
        feedback_sample <= 1'b1;
        smp_due <= 1'b0;
      end
      if (smp_cnt == 24'h00_0000) begin
        smp_due <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feedback ceiling ramp and mapped level
  always_ff @(posedge mclk) begin
    if (reset) begin
      ceiling <= CEILING_RAMP_START;
    end else if (regulated_entry) begin
      ceiling <= CEILING_RAMP_START;
    end else if (half_line_tick) begin
      if (17'(ceiling) + 17'(cfg[REG_RAMP_INC]) >= 17'(CEILING_RAMP_FINAL)) begin
        ceiling <= CEILING_RAMP_FINAL;
      end else begin
        ceiling <= ceiling + cfg[REG_RAMP_INC];
      end
    end
  end

  always_comb begin
    if (feedback_level_filtered > ceiling) begin
      fb_map = ceiling;
    end else begin
      fb_map = feedback_level_filtered;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-line limit computation
  always_comb begin
    logic [31:0] q;
    logic [47:0] red;
    q = 32'h0000_0000;
    red = 48'h0000_0000_0000;
    if (vin_peak != 16'h0000) begin
      q = (32'(cfg[REG_DEMAG_MIN]) * 32'(cfg[REG_VOUT_OV])) / 32'(vin_peak);
    end
    ton_sense = (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
    if (ton_sense > cfg[REG_TON_MIN]) begin
      ton_eff = ton_sense;
    end else begin
      ton_eff = cfg[REG_TON_MIN];
    end
    ton_max_calc = cfg[REG_TON_MAX_LOW];
    if (vin_estimate >= cfg[REG_VIN_LOW]) begin
      if (vin_estimate != 16'h0000) begin
        q = (32'(cfg[REG_TON_MAX_LOW]) * 32'(cfg[REG_VIN_LOW]))
          / 32'(vin_estimate);
        ton_max_calc = q[15:0];
      end
    end else begin
      red = (48'(cfg[REG_TON_MAX_LOW]) * 48'(cfg[REG_FOLDBACK_GAIN])
        * 48'(cfg[REG_VIN_LOW] - vin_estimate))
        / (48'(cfg[REG_VIN_LOW]) << 8);
      if (red >= 48'(cfg[REG_TON_MAX_LOW])) begin
        ton_max_calc = 16'h0000;
      end else begin
        ton_max_calc = cfg[REG_TON_MAX_LOW] - red[15:0];
      end
    end
    ocp_calc = interp(cfg[REG_OCP_LOW], cfg[REG_OCP_HIGH], vin_estimate,
      cfg[REG_VIN_LOW], cfg[REG_VIN_HIGH]);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ton_min_hl <= 16'h0000;
      ton_max_hl <= 16'h0000;
      ocp_hl <= 16'h0000;
    end else if (half_line_tick) begin
      ton_min_hl <= ton_eff;
      ton_max_hl <= ton_max_calc;
      ocp_hl <= ocp_calc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mapping of feedback onto period and on-time
  always_comb begin
    min_period = interp(BURST_SWITCH_PERIOD, cfg[REG_PERIOD_MIN], fb_map,
      BURST_ENTRY_THRESHOLD, MAX_FREQUENCY_THRESHOLD);
    if (fb_map < ONTIME_CONTROL_THRESHOLD) begin
      ton_reg = ton_min_hl;
    end else begin
      ton_reg = interp(ton_min_hl, ton_max_hl, fb_map,
        ONTIME_CONTROL_THRESHOLD, cfg[REG_FB_FULL]);
    end
    if (fb_burst <= cfg[REG_FB_FLOOR]) begin
      burst_ton = cfg[REG_BURST_ON];
      burst_pulses = cfg[REG_BURST_PULSES];
    end else begin
      burst_ton = interp(cfg[REG_BURST_ON], ton_min_hl, fb_burst,
        cfg[REG_FB_FLOOR], BURST_ENTRY_THRESHOLD);
      burst_pulses = cfg[REG_BURST_PULSES]
        + ((fb_burst - cfg[REG_FB_FLOOR]) >> 4);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fb_burst <= 16'h0000;
    end else if (burst_last_pulse) begin
      fb_burst <= fb_map;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_cnt <= 16'h0000;
    end else if (mode == BURST_MODE || fb_map >= BURST_ENTRY_THRESHOLD) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      BURST_MODE: begin
        if (fb_map > BURST_ENTRY_THRESHOLD) begin
          next_mode = DISCONTINUOUS_MODE;
        end
      end
      DISCONTINUOUS_MODE, FIRST_VALLEY_MODE: begin
        if (fb_map < BURST_ENTRY_THRESHOLD
            && low_cnt >= cfg[REG_BURST_BLANK]) begin
          next_mode = BURST_MODE;
        end else if (fb_map >= ONTIME_CONTROL_THRESHOLD
            && min_period < first_valley_period) begin
          next_mode = FIRST_VALLEY_MODE;
        end else begin
          next_mode = DISCONTINUOUS_MODE;
        end
      end
      default: begin
        next_mode = DISCONTINUOUS_MODE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode <= DISCONTINUOUS_MODE;
    end else if (cycle_start) begin
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limits handed to the gate generator, fixed per switching cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      limits <= '{mode: DISCONTINUOUS_MODE, period: BURST_SWITCH_PERIOD,
        default: 16'h0000};
    end else if (cycle_start) begin
      limits.mode <= next_mode;
      limits.ocp <= ocp_hl;
      if (next_mode == BURST_MODE) begin
        limits.ton_min <= cfg[REG_BURST_ON];
        limits.ton_max <= ton_max_hl;
        limits.ton_cmd <= burst_ton;
        limits.period <= BURST_SWITCH_PERIOD;
        limits.pulses <= burst_pulses;
      end else begin
        limits.ton_min <= ton_min_hl;
        limits.ton_max <= ton_max_hl;
        limits.pulses <= 16'h0000;
        if (next_mode == FIRST_VALLEY_MODE) begin
          limits.ton_cmd <= ton_reg;
          limits.period <= first_valley_period;
        end else begin
          limits.ton_cmd <= ton_reg;
          limits.period <= min_period;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      burst_repeat_period <= CFG_RESET[REG_BURST_REPEAT];
      out_protect_enable <= 1'b1;
      in_protect_enable <= 1'b1;
    end else begin
      burst_repeat_period <= cfg[REG_BURST_REPEAT];
      out_protect_enable <= mode != BURST_MODE;
      in_protect_enable <= mode != BURST_MODE
        || cfg[REG_CTRL][CTRL_IN_PROT_BIT];
    end
  end

endmodule : fbm_mapper
`default_nettype wire

// ==== dv/fbm_mapper_assertions.sv ====
/*
  Port checker of the flyback mode and limit mapper.
  Assumes one clock and the synchronous reset of the mapper; bound below.
*/
`timescale 1ns/100ps
`default_nettype none
module fbm_mapper_assertions
  import fbm_pkg::*;
#(
  parameter int HALF_LINE_CYCLES = 640
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] feedback_level_filtered,
  input wire logic [15:0] vin_estimate,
  input wire logic [15:0] vin_peak,
  input wire logic [15:0] first_valley_period,
  input wire logic line_sync_valid,
  input wire logic [23:0] line_half_period,
  input wire logic regulated_entry,
  input wire logic cycle_start,
  input wire logic gate_on,
  input wire logic burst_last_pulse,
  input wire logic burst_sleep,
  input wire logic cs_over_pin,
  input wire fbm_limits_t limits,
  input wire logic [15:0] burst_repeat_period,
  input wire logic cs_limit_hit,
  input wire logic feedback_sample,
  input wire logic out_protect_enable,
  input wire logic in_protect_enable,
  input wire logic half_line_tick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  logic ctrl_q;
  logic hl_seen;
  logic [31:0] hl_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Helper state
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= 1'b0;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata[CTRL_IN_PROT_BIT];
    end
  end
  always_ff @(posedge mclk) begin
    if (reset || half_line_tick) begin
      hl_cnt <= 32'h0;
    end else begin
      hl_cnt <= hl_cnt + 32'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      hl_seen <= 1'b0;
    end else if (half_line_tick) begin
      hl_seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_hold;
    !cycle_start |=> $stable(limits);
  endproperty
  a_hold: assert property (p_hold) else $error("limits moved");
  property p_burst_period;
    limits.mode == BURST_MODE |-> limits.period == BURST_SWITCH_PERIOD;
  endproperty
  a_burst_period: assert property (p_burst_period) else $error("period");
  property p_out_prot;
    $past(limits.mode) == BURST_MODE && limits.mode == BURST_MODE
      |-> !out_protect_enable;
  endproperty
  a_out_prot: assert property (p_out_prot) else $error("out prot");
  property p_in_prot;
    $past(limits.mode) == limits.mode && !$past(reg_wr)
      |-> in_protect_enable == (limits.mode != BURST_MODE || ctrl_q);
  endproperty
  a_in_prot: assert property (p_in_prot) else $error("in prot");
  property p_cs_blank;
    cycle_start |=> !cs_limit_hit [*8] ##1 !cs_limit_hit [*4];
  endproperty
  a_cs_blank: assert property (p_cs_blank) else $error("blank");
  property p_cs_hit;
    cycle_start ##1 (gate_on && cs_over_pin) [*7]
      ##1 (gate_on && cs_over_pin) [*7] |-> ##[1:3] cs_limit_hit;
  endproperty
  a_cs_hit: assert property (p_cs_hit) else $error("no hit");
  property p_exit;
    cycle_start && limits.mode == BURST_MODE
      && feedback_level_filtered > BURST_ENTRY_THRESHOLD
      |=> limits.mode == DISCONTINUOUS_MODE;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");
  property p_entry;
    cycle_start && limits.mode != BURST_MODE
      && feedback_level_filtered >= BURST_ENTRY_THRESHOLD
      |=> limits.mode != BURST_MODE;
  endproperty
  a_entry: assert property (p_entry) else $error("early burst");
  property p_tick;
    half_line_tick && hl_seen && !line_sync_valid
      |-> hl_cnt == HALF_LINE_CYCLES - 1;
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing");
  property p_sleep;
    burst_sleep ##1 burst_sleep |-> !feedback_sample;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sample");
endmodule : fbm_mapper_assertions

bind fbm_mapper fbm_mapper_assertions #(
  .HALF_LINE_CYCLES(HALF_LINE_CYCLES)
) fbm_mapper_assertions_inst (.*);
`default_nettype wire

// ==== dv/fbm_gate_model.sv ====
/*
  Gate pulse generator model facing the mapper.
  Assumes the mapper limits; cs_force raises the comparator while gate on.
*/
`timescale 1ns/100ps
`default_nettype none
module fbm_gate_model
  import fbm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire fbm_limits_t limits,
  input wire logic cs_force,
  output logic cycle_start,
  output logic gate_on,
  output logic burst_last_pulse,
  output logic burst_sleep,
  output logic cs_over_pin
);
  logic [16:0] cnt;
  logic [16:0] len;
  logic [16:0] ton;
  logic burst;

  // Cycle is the minimum period or on-time plus ringing
  assign ton = 17'(limits.ton_cmd);
  assign len = (17'(limits.period) > ton + 17'h8) ?
    17'(limits.period) : ton + 17'h8;
  always_ff @(posedge mclk) begin
    if (reset || cnt + 17'h1 >= len) begin
      cnt <= 17'h0;
    end else begin
      cnt <= cnt + 17'h1;
    end
  end
  assign burst = limits.mode == BURST_MODE;
  assign cycle_start = !reset && cnt == 17'h0;
  assign gate_on = !reset && cnt < ton;
  assign burst_last_pulse = cycle_start && burst;
  assign burst_sleep = burst && !gate_on;
  assign cs_over_pin = gate_on && cs_force;
endmodule : fbm_gate_model
`default_nettype wire

// ==== dv/fbm_mapper_tb.sv ====
/*
  Testbench of the mapper driven by the gate pulse model.
  Assumes package, mapper, checker and model compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module fbm_mapper_tb
  import fbm_pkg::*;
;
  localparam int HL = 640;
  localparam logic [15:0] TAB [0:2][0:4] = '{
    '{16'h00C8, 16'h03E8, 16'h000A, 16'h00C8, 16'h02BC},
    '{16'h004B, 16'h0064, 16'h0032, 16'h012C, 16'h0320},
    '{16'h0190, 16'h03E8, 16'h000A, 16'h0064, 16'h0258}};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] feedback_level_filtered = 16'h03E8;
  logic [15:0] vin_estimate = 16'h00C8;
  logic [15:0] vin_peak = 16'h03E8;
  logic [15:0] first_valley_period = 16'h012C;
  logic line_sync_valid = 1'b0;
  logic [23:0] line_half_period = 24'h0;
  logic regulated_entry = 1'b0;
  logic cs_force = 1'b0;
  logic cycle_start, gate_on, burst_last_pulse, burst_sleep, cs_over_pin;
  fbm_limits_t limits;
  logic [15:0] burst_repeat_period;
  logic cs_limit_hit, feedback_sample, out_protect_enable;
  logic in_protect_enable, half_line_tick;
  logic [31:0] rd_val;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  fbm_mapper #(.HALF_LINE_CYCLES(HL)) fbm_mapper_inst (.*);
  fbm_gate_model fbm_gate_model_inst (.*);

  initial begin
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic close_out();
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    cyc(1);
    reg_addr <= a;
    reg_wdata <= {16'h0000, d};
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    cyc(1);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd
  task automatic wait_ev(input bit tick, input int n);
    repeat (n) begin
      cyc(1);
      for (int i = 0; i < 3000; i++) begin
        if ((tick ? half_line_tick : cycle_start) === 1'b1) break;
        cyc(1);
      end
    end
    #1;
  endtask : wait_ev
  task automatic wait_mode(input fbm_mode_t m);
    for (int i = 0; i < 4000 && limits.mode !== m; i++) cyc(1);
    #1;
    chk(32'(limits.mode), 32'(m));
  endtask : wait_mode

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    for (int i = 0; i < CFG_N; i++) begin
      rd(5'(i));
      chk(rd_val, 32'(CFG_RESET[i]));
    end
    chk(32'(burst_repeat_period), 32'(CFG_RESET[17]));
    chk(32'(out_protect_enable), 32'h1);
    wr(5'h12, 16'h1234);
    rd(5'h12);
    chk(rd_val, 32'h0);
    wr(REG_BURST_REPEAT, 16'h4E20);
    cyc(2);
    chk(32'(burst_repeat_period), 32'h4E20);
    line_sync_valid <= 1'b1;
    line_half_period <= 24'h00_0140;
    wait_ev(1'b1, 2);
    rd_val = 32'h0;
    do begin
      cyc(1);
      rd_val++;
    end while (half_line_tick !== 1'b1 && rd_val < 32'h200);
    chk(rd_val, 32'h140);
    line_sync_valid <= 1'b0;
    $display("t_regs done");
  endtask : t_regs
  task automatic t_limits();
    for (int r = 0; r < 3; r++) begin
      cyc(1);
      vin_estimate <= TAB[r][0];
      vin_peak <= TAB[r][1];
      wait_ev(1'b1, 1);
      wait_ev(1'b0, 1);
      chk(32'(limits.ton_min), 32'(TAB[r][2]));
      chk(32'(limits.ton_max), 32'(TAB[r][3]));
      chk(32'(limits.ocp), 32'(TAB[r][4]));
      chk(32'(limits.ton_cmd), 32'(TAB[r][2]));
      chk(32'(limits.mode), 32'(DISCONTINUOUS_MODE));
      chk(32'(limits.period < 16'h04E2 && limits.period > 16'h0064),
        32'h1);
      for (int i = 0; i < 1400 && feedback_sample !== 1'b1; i++) cyc(1);
      chk(32'(feedback_sample), 32'h1);
    end
    $display("t_limits done");
  endtask : t_limits
  task automatic t_valley();
    cyc(1);
    feedback_level_filtered <= 16'h09C4;
    wait_ev(1'b1, 1);
    cyc(1);
    regulated_entry <= 1'b1;
    cyc(1);
    regulated_entry <= 1'b0;
    rd(REG_STATUS);
    chk(32'(rd_val[15:0]), 32'(CEILING_RAMP_START));
    wait_ev(1'b0, 2);
    chk(32'(limits.mode), 32'(DISCONTINUOUS_MODE));
    wr(REG_RAMP_INC, 16'h0400);
    wait_ev(1'b1, 3);
    rd(REG_STATUS);
    chk(32'(rd_val[15:0]), 32'(CEILING_RAMP_FINAL));
    wait_ev(1'b0, 2);
    chk(32'(limits.mode), 32'(FIRST_VALLEY_MODE));
    chk(32'(limits.period), 32'h012C);
    chk(32'(limits.ton_cmd), 32'(TAB[2][3]));
    cyc(1);
    first_valley_period <= 16'h0032;
    wait_ev(1'b0, 2);
    chk(32'(limits.mode), 32'(DISCONTINUOUS_MODE));
    chk(32'(limits.period), 32'(CFG_RESET[8]));
    cyc(1);
    first_valley_period <= 16'h012C;
    cs_force <= 1'b1;
    for (int i = 0; i < 600 && cs_limit_hit !== 1'b1; i++) cyc(1);
    chk(32'(cs_limit_hit), 32'h1);
    wait_ev(1'b0, 2);
    cyc(1);
    cs_force <= 1'b0;
    $display("t_valley done");
  endtask : t_valley
  task automatic t_burst();
    wr(REG_BURST_BLANK, 16'h0800);
    cyc(1);
    feedback_level_filtered <= 16'h01F4;
    wait_ev(1'b0, 1);
    chk(32'(limits.mode == BURST_MODE), 32'h0);
    wait_mode(BURST_MODE);
    wait_ev(1'b0, 2);
    chk(32'(limits.period), 32'(BURST_SWITCH_PERIOD));
    chk(32'(limits.pulses), 32'(CFG_RESET[10]));
    chk(32'(limits.ton_cmd), 32'(CFG_RESET[11]));
    chk(32'({out_protect_enable, in_protect_enable}), 32'h0);
    wr(REG_CTRL, 16'h0001);
    cyc(3);
    chk(32'(in_protect_enable), 32'h1);
    feedback_level_filtered <= 16'h02BC;
    wait_ev(1'b0, 3);
    chk(32'(limits.pulses), 32'h0008);
    cyc(1);
    feedback_level_filtered <= 16'h03E8;
    wait_mode(DISCONTINUOUS_MODE);
    $display("t_burst done");
  endtask : t_burst

  initial begin
    cyc(2);
    reset <= 1'b0;
    t_regs();
    t_limits();
    t_valley();
    t_burst();
    close_out();
  end
endmodule : fbm_mapper_tb
`default_nettype wire
